// ---- tsr_pkg.sv ----
// Purpose: shared constants for the trace sync/id/timestamp/filter registers
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes:   offsets, field positions and the period and event reset values live only here
`default_nettype none

package tsr_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_SYNC   = 8'h00;
    localparam logic [7:0] OFF_ID     = 8'h04;
    localparam logic [7:0] OFF_TS     = 8'h08;
    localparam logic [7:0] OFF_RANGE  = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam int         ADDR_W     = 8;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int PERIOD_W  = 5;
    localparam int EVENT_W   = 8;
    localparam int EXCL_LSB  = 16;
    localparam int STAT_EN   = 0;
    localparam int STAT_DROP = 1;
    localparam int STAT_FIX  = 2;
    localparam int STAT_TS   = 3;
    localparam int STAT_RNG  = 4;
    localparam int STAT_IDW  = 8;
    localparam int STAT_NP   = 16;

    // ------------------------------------------------------------------
    // period encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [4:0]  PERIOD_OFF     = 5'h00;
    localparam logic [4:0]  PERIOD_MIN     = 5'h08;
    localparam logic [4:0]  PERIOD_MAX     = 5'h14;
    localparam logic [4:0]  FIXED_PER_DEF  = 5'h0A;
    localparam logic [4:0]  PERIOD_RST     = 5'h00;
    localparam logic [7:0]  EVENT_RST      = 8'h00;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

endpackage

`default_nettype wire

// ---- tsr_bus_if.sv ----
// Purpose: register access strobes between bus front end and register bank
// Assumes: one access per cycle, data phase timing
// Notes:   rdata is combinational from register flops
`default_nettype none

interface tsr_bus_if;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport slave (output wr_en, output rd_en, output addr, output wdata,
                   input rdata);
    modport regs  (input wr_en, input rd_en, input addr, input wdata,
                   output rdata);
endinterface

`default_nettype wire

// ---- tsr_ahb_slave.sv ----
// Purpose: AHB-Lite slave front end, zero wait states, always OKAY
// Assumes: single whole-word transfers; hsize not checked
// Notes:   addresses above the low byte window read zero, writes dropped
`default_nettype none

module tsr_ahb_slave (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    tsr_bus_if.slave         bus
);
    import tsr_pkg::*;

    logic             wr_ph_r;
    logic             rd_ph_r;
    logic [ADDR_W-1:0] addr_r;
    logic             take;

    // ------------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------------
    assign take = hsel_i & htrans_i[1] & (haddr_i[31:ADDR_W] == '0);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_ph_r <= 1'b0;
            rd_ph_r <= 1'b0;
            addr_r  <= '0;
        end else if (hready_i) begin
            wr_ph_r <= take & hwrite_i;
            rd_ph_r <= take & ~hwrite_i;
            if (take) begin
                addr_r <= haddr_i[ADDR_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // data phase
    // ------------------------------------------------------------------
    // read muxes the register flops in the data phase, so a read right
    // after a write already sees the new value
    assign bus.wr_en   = wr_ph_r;
    assign bus.rd_en   = rd_ph_r;
    assign bus.addr    = addr_r;
    assign bus.wdata   = hwdata_i;
    assign hrdata_o    = rd_ph_r ? bus.rdata : WORD_ZERO;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

endmodule

`default_nettype wire

// ---- tsr_sync_counter.sv ----
// Purpose: counts trace bytes and pulses a sync request every 2^period
// Assumes: run_i low clears the count
// Notes:   invalid period codes generate no requests
`default_nettype none

module tsr_sync_counter #(
    parameter int CNT_W   = 21,
    parameter int BYTES_W = 4
) (
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          run_i,
    input  wire logic [tsr_pkg::PERIOD_W-1:0]  period_i,
    input  wire logic [BYTES_W-1:0]            bytes_i,
    output logic                               sync_req_o
);
    import tsr_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W:0]   sum;
    logic [CNT_W:0]   limit;
    logic             valid;

    assign valid = (period_i >= PERIOD_MIN) && (period_i <= PERIOD_MAX);
    assign limit = (CNT_W+1)'(1) << period_i;
    assign sum   = {1'b0, cnt_r} + (CNT_W+1)'(bytes_i);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !run_i || !valid) begin
            cnt_r      <= '0;
            sync_req_o <= 1'b0;
        end else if (sum >= limit) begin
            cnt_r      <= CNT_W'(sum - limit);
            sync_req_o <= 1'b1;
        end else begin
            cnt_r      <= CNT_W'(sum);
            sync_req_o <= 1'b0;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_sync_off_quiet: assert property (
        (period_i == PERIOD_OFF) |=> !sync_req_o)
        else $error("sync request while period is off");
    a_sync_needs_valid: assert property (
        sync_req_o |-> $past(valid) && $past(run_i))
        else $error("sync request from invalid period or stopped unit");

endmodule

`default_nettype wire

// ---- tsr_regs_top.sv ----
// Purpose: sync period, source id, timestamp event and data range registers
// Assumes: trace_enable_i is the unit enable; bytes_i counts emitted trace
// Notes:   registers read/written over AHB-Lite, zero wait states
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`default_nettype none

// Contract
// - fixed-period flag set: period register read-only, holds chosen value
// - invalid period code: counter may emit no, programmed, or other requests
// - reset: writable period takes unknown, read-only one its chosen value
// - sync request every 2^period bytes for 8..20; zero stops periodic ones
// - instruction trace uses source id, data trace uses id plus one
// - the four registers take writes only while the unit is disabled
// - id width from capability; bits beyond width or pairs read zero
// - on the standard trace bus the source id is 7 bits wide
// - reserved id values do not change this unit's behaviour
// - selected 8-bit event inserts a global timestamp each time it fires
// - timestamp control exists only if timestamp size capability nonzero
// - pair tied to a data value comparator gives unpredictable filtering
// - range select exists only with data trace and comparator pairs
// - exclude bits from 16 upward, bit m selects pair m-16
// - include bits from 0; none included means include all transfers
module tsr_regs_top #(
    parameter bit   FIXED_SYNC   = 1'b0,
    parameter logic [4:0] FIXED_PERIOD = tsr_pkg::FIXED_PER_DEF,
    parameter int   ID_W         = 7,
    parameter int   TS_SIZE_CAP  = 64,
    parameter bit   DATA_IMPL    = 1'b1,
    parameter int   NUM_PAIRS    = 8,
    parameter int   NUM_EVT      = 16,
    parameter int   BYTES_W      = 4
) (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    output logic [31:0]               hrdata_o,
    input  wire logic                 trace_enable_i,
    input  wire logic                 data_trace_enable_i,
    input  wire logic [BYTES_W-1:0]   trace_bytes_i,
    input  wire logic [NUM_EVT-1:0]   event_vec_i,
    input  wire logic                 sac_include_any_i,
    output logic                      sync_req_o,
    output logic [ID_W-1:0]           inst_source_id_o,
    output logic [ID_W-1:0]           data_source_id_o,
    output logic                      data_source_id_valid_o,
    output logic                      ts_insert_o,
    output logic [NUM_PAIRS-1:0]      include_sel_o,
    output logic [NUM_PAIRS-1:0]      exclude_sel_o,
    output logic                      include_all_o
);
    import tsr_pkg::*;

    // ------------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------------
    localparam bit TS_PRESENT  = (TS_SIZE_CAP != 0);
    localparam bit RNG_PRESENT = DATA_IMPL && (NUM_PAIRS > 0);
    localparam int SEL_W       = (NUM_EVT > 1) ? $clog2(NUM_EVT) : 1;

    tsr_bus_if bus ();

    logic [PERIOD_W-1:0]  period_r;
    logic [ID_W-1:0]      id_r;
    logic [EVENT_W-1:0]   ts_evt_r;
    logic [NUM_PAIRS-1:0] incl_r;
    logic [NUM_PAIRS-1:0] excl_r;
    logic                 drop_r;
    logic                 wr_ok;
    logic                 locked_hit;
    logic                 ev_sel;
    logic                 incl_none;
    logic [31:0]          wdata_q;

    // ------------------------------------------------------------------
    // bus front end and sync counter
    // ------------------------------------------------------------------
    tsr_ahb_slave u_ahb (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hwdata_i    (hwdata_i),
        .hready_i    (hready_i),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .hrdata_o    (hrdata_o),
        .bus         (bus.slave)
    );

    tsr_sync_counter #(
        .CNT_W   (21),
        .BYTES_W (BYTES_W)
    ) u_sync (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .run_i      (trace_enable_i),
        .period_i   (period_r),
        .bytes_i    (trace_bytes_i),
        .sync_req_o (sync_req_o)
    );

    // ------------------------------------------------------------------
    // write gating
    // ------------------------------------------------------------------
    // enabled-unit writes to the four registers are dropped silently on the bus; the sticky
    // status bit is the only way software can see that it happened
    assign wr_ok      = bus.wr_en & ~trace_enable_i;
    assign locked_hit = bus.wr_en & trace_enable_i &
                        (bus.addr inside {OFF_SYNC, OFF_ID, OFF_TS,
                                          OFF_RANGE});

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            period_r <= FIXED_SYNC ? FIXED_PERIOD : PERIOD_RST;
        end else if (!FIXED_SYNC && wr_ok && bus.addr == OFF_SYNC) begin
            period_r <= bus.wdata[PERIOD_W-1:0];
        end
    end

    // any id value is stored as given, reserved codes included
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            id_r <= '0;
        end else if (wr_ok && bus.addr == OFF_ID) begin
            id_r <= bus.wdata[ID_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ts_evt_r <= EVENT_RST;
        end else if (TS_PRESENT && wr_ok && bus.addr == OFF_TS) begin
            ts_evt_r <= bus.wdata[EVENT_W-1:0];
        end
    end

    // no cross-check against comparator modes: a pair tied to a data
    // value comparator filters unpredictably, as software was warned
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            incl_r <= '0;
            excl_r <= '0;
        end else if (RNG_PRESENT && wr_ok && bus.addr == OFF_RANGE) begin
            incl_r <= bus.wdata[NUM_PAIRS-1:0];
            excl_r <= bus.wdata[EXCL_LSB +: NUM_PAIRS];
        end
    end

    // set wins over the write-one clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            drop_r <= 1'b0;
        end else if (locked_hit) begin
            drop_r <= 1'b1;
        end else if (bus.wr_en && bus.addr == OFF_STATUS &&
                     bus.wdata[STAT_DROP]) begin
            drop_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        bus.rdata = WORD_ZERO;
        unique case (bus.addr)
            OFF_SYNC:  bus.rdata[PERIOD_W-1:0] = period_r;
            OFF_ID:    bus.rdata[ID_W-1:0]     = id_r;
            OFF_TS:    bus.rdata[EVENT_W-1:0]  = ts_evt_r;
            OFF_RANGE: begin
                bus.rdata[NUM_PAIRS-1:0]        = incl_r;
                bus.rdata[EXCL_LSB +: NUM_PAIRS] = excl_r;
            end
            OFF_STATUS: begin
                bus.rdata[STAT_EN]      = trace_enable_i;
                bus.rdata[STAT_DROP]    = drop_r;
                bus.rdata[STAT_FIX]     = FIXED_SYNC;
                bus.rdata[STAT_TS]      = TS_PRESENT;
                bus.rdata[STAT_RNG]     = RNG_PRESENT;
                bus.rdata[STAT_IDW +: 8] = 8'(ID_W);
                bus.rdata[STAT_NP +: 8]  = 8'(NUM_PAIRS);
            end
            default:   bus.rdata = WORD_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // trace-side outputs
    // ------------------------------------------------------------------
    // only the low selector bits index events; wider resource
    // selection belongs to the event logic outside
    assign ev_sel    = TS_PRESENT && event_vec_i[ts_evt_r[SEL_W-1:0]];
    assign incl_none = (incl_r == '0) && !sac_include_any_i;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            inst_source_id_o       <= '0;
            data_source_id_o       <= '0;
            data_source_id_valid_o <= 1'b0;
        end else begin
            inst_source_id_o       <= id_r;
            data_source_id_o       <= ID_W'(id_r + 1'b1);
            data_source_id_valid_o <= data_trace_enable_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ts_insert_o <= 1'b0;
        end else begin
            ts_insert_o <= ev_sel & trace_enable_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            include_sel_o <= '0;
            exclude_sel_o <= '0;
            include_all_o <= 1'b1;
        end else begin
            include_sel_o <= incl_r;
            exclude_sel_o <= excl_r;
            include_all_o <= incl_none;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        wdata_q <= bus.wdata;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_fixed_period_ro: assert property (
        FIXED_SYNC |-> period_r == FIXED_PERIOD)
        else $error("fixed sync period changed");
    a_locked_write: assert property (
        (bus.wr_en && trace_enable_i) |=> $stable(period_r) &&
        $stable(id_r) && $stable(ts_evt_r) && $stable(incl_r) &&
        $stable(excl_r) && (drop_r || !$past(locked_hit)))
        else $error("register changed while unit enabled");
    a_id_readback: assert property (
        (wr_ok && bus.addr == OFF_ID) |=> id_r == wdata_q[ID_W-1:0])
        else $error("source id not stored");
    a_data_id_step: assert property (
        data_trace_enable_i |=> data_source_id_valid_o &&
        data_source_id_o == ID_W'($past(id_r) + 1'b1))
        else $error("data id is not instruction id plus one");
    a_id_upper_zero: assert property (
        (bus.rd_en && bus.addr == OFF_ID) |-> bus.rdata[31:ID_W] == '0)
        else $error("id bits above width read nonzero");
    a_ts_insert: assert property (
        ##1 ts_insert_o == ($past(ev_sel) && $past(trace_enable_i)))
        else $error("timestamp insert not tied to selected event");
    a_ts_absent: assert property (
        !TS_PRESENT |-> !ts_insert_o && ts_evt_r == '0)
        else $error("timestamp control active while absent");
    a_range_absent: assert property (
        !RNG_PRESENT |-> incl_r == '0 && excl_r == '0)
        else $error("range select active while absent");
    a_include_all: assert property (
        ##1 include_all_o == $past(incl_none))
        else $error("include-all default wrong");

endmodule

`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench for the trace config register bank
// Assumes: default parameters, zero-wait AHB-Lite slave, hready looped back
// Notes:   fixed-period build not covered here; one bus master only
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tsr_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst   = 1'b1;
    logic        hsel  = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic        ten   = 1'b0;
    logic        dten  = 1'b0;
    logic        sac   = 1'b0;
    logic [3:0]  tbytes = 4'h0;
    logic [15:0] evec  = 16'h0;
    logic        hready, hresp, sync_req, dvalid, ts_ins, inc_all;
    logic [31:0] hrdata;
    logic [6:0]  iid, did;
    logic [7:0]  inc_sel, exc_sel;
    int          bad_count = 0;
    int          checked = 0;
    int          cyc = 0;

    always #12.5 clk_i = ~clk_i;

    tsr_regs_top u_dut (
        .clk_i(clk_i), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
        .hresp_o(hresp), .hrdata_o(hrdata), .trace_enable_i(ten),
        .data_trace_enable_i(dten), .trace_bytes_i(tbytes),
        .event_vec_i(evec), .sac_include_any_i(sac),
        .sync_req_o(sync_req), .inst_source_id_o(iid),
        .data_source_id_o(did), .data_source_id_valid_o(dvalid),
        .ts_insert_o(ts_ins), .include_sel_o(inc_sel),
        .exclude_sel_o(exc_sel), .include_all_o(inc_all));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard, generous for about 2300 cycles of tests
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // address phase held until hready, then data phase until hready
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rchk(input string what, input logic [31:0] a,
                        input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(what, r, exp);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_fields;
        logic [31:0] offs [4] = '{32'h00, 32'h04, 32'h08, 32'h0C};
        logic [31:0] mask [4] = '{32'h1F, 32'h7F, 32'hFF, 32'h00FF_00FF};
        for (int k = 0; k < 4; k++) begin
            rchk("reset value", offs[k], 32'h0);
            wr(offs[k], 32'hFFFF_FFFF);
            rchk("ones readback", offs[k], mask[k]);
            wr(offs[k], 32'hA5A5_5A5A);
            rchk("mixed readback", offs[k], 32'hA5A5_5A5A & mask[k]);
        end
        wr(32'h0000_0100, 32'h0000_0003);
        rchk("no alias", {24'h0, OFF_SYNC}, 32'h1A);
        rchk("unmapped", 32'h0000_0014, 32'h0);
        $display("test fields done");
    endtask

    task automatic t_lock;
        wr({24'h0, OFF_SYNC}, 32'h08);
        wr({24'h0, OFF_ID}, 32'h10);
        wr({24'h0, OFF_TS}, 32'h01);
        wr({24'h0, OFF_RANGE}, 32'h0002_0004);
        ten <= 1'b1;
        @(posedge clk_i);
        wr({24'h0, OFF_SYNC}, 32'h0C);
        wr({24'h0, OFF_ID}, 32'h22);
        wr({24'h0, OFF_TS}, 32'h07);
        wr({24'h0, OFF_RANGE}, 32'h0010_0010);
        rchk("locked period", {24'h0, OFF_SYNC}, 32'h08);
        rchk("locked id", {24'h0, OFF_ID}, 32'h10);
        rchk("locked ts", {24'h0, OFF_TS}, 32'h01);
        rchk("locked range", {24'h0, OFF_RANGE}, 32'h0002_0004);
        rchk("drop status", {24'h0, OFF_STATUS}, 32'h0008_071B);
        ten <= 1'b0;
        @(posedge clk_i);
        wr({24'h0, OFF_STATUS}, 32'h0000_0002);
        rchk("drop cleared", {24'h0, OFF_STATUS}, 32'h0008_0718);
        $display("test lock done");
    endtask

    task automatic t_ids;
        logic [6:0] v [3] = '{7'h7E, 7'h70, 7'h10};
        for (int k = 0; k < 3; k++) begin
            wr({24'h0, OFF_ID}, {25'h0, v[k]});
            dten <= 1'b1;
            repeat (3) @(posedge clk_i);
            chk("inst id", {25'h0, iid}, {25'h0, v[k]});
            chk("data id", {25'h0, did}, {25'h0, v[k] + 7'h1});
            chk("data id valid", {31'h0, dvalid}, 32'h1);
            dten <= 1'b0;
            repeat (2) @(posedge clk_i);
            chk("data id off", {31'h0, dvalid}, 32'h0);
        end
        $display("test ids done");
    endtask

    task automatic t_sync;
        int n;
        logic [4:0] badp [3] = '{5'h00, 5'h07, 5'h15};
        tbytes <= 4'h4;
        for (int k = 8; k < 10; k++) begin
            wr({24'h0, OFF_SYNC}, k);
            ten <= 1'b1;
            n = 0;
            while (sync_req !== 1'b1 && n < 2000) begin
                @(posedge clk_i);
                n++;
            end
            @(posedge clk_i);
            chk("sync pulse width", {31'h0, sync_req}, 32'h0);
            n = 1;
            while (sync_req !== 1'b1 && n < 2000) begin
                @(posedge clk_i);
                n++;
            end
            chk("sync gap", n, (1 << k) / 4);
            ten <= 1'b0;
            @(posedge clk_i);
        end
        tbytes <= 4'hF;
        for (int k = 0; k < 3; k++) begin
            wr({24'h0, OFF_SYNC}, {27'h0, badp[k]});
            ten <= 1'b1;
            n = 0;
            repeat (600) begin
                @(posedge clk_i);
                n += int'(sync_req === 1'b1);
            end
            chk("no sync", n, 0);
            ten <= 1'b0;
            @(posedge clk_i);
        end
        $display("test sync done");
    endtask

    task automatic t_ts;
        wr({24'h0, OFF_TS}, 32'h03);
        ten <= 1'b1;
        @(posedge clk_i);
        evec <= 16'h0008;
        @(posedge clk_i);
        evec <= 16'h0004;
        @(posedge clk_i);
        chk("ts on event", {31'h0, ts_ins}, 32'h1);
        evec <= 16'h0000;
        @(posedge clk_i);
        chk("ts other event", {31'h0, ts_ins}, 32'h0);
        ten <= 1'b0;
        evec <= 16'h0008;
        repeat (2) @(posedge clk_i);
        chk("ts while off", {31'h0, ts_ins}, 32'h0);
        evec <= 16'h0000;
        $display("test ts done");
    endtask

    task automatic t_range;
        wr({24'h0, OFF_RANGE}, 32'h0001_0000);
        repeat (3) @(posedge clk_i);
        chk("exclude", {24'h0, exc_sel}, 32'h01);
        chk("include all", {31'h0, inc_all}, 32'h1);
        sac <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("sac include", {31'h0, inc_all}, 32'h0);
        sac <= 1'b0;
        wr({24'h0, OFF_RANGE}, 32'h0080_0080);
        repeat (3) @(posedge clk_i);
        chk("include sel", {24'h0, inc_sel}, 32'h80);
        chk("exclude top", {24'h0, exc_sel}, 32'h80);
        chk("range include", {31'h0, inc_all}, 32'h0);
        $display("test range done");
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst <= 1'b0;
        @(posedge clk_i);
        chk("reset include all", {31'h0, inc_all}, 32'h1);
        t_fields();
        t_lock();
        t_ids();
        t_sync();
        t_ts();
        t_range();
        report_and_stop();
    end
endmodule

`default_nettype wire
